// *** rtl/rxsp_ctrl.sv ***
// Receiver status pins, source selection and clock status pulse
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// RULE_01 - Error condition off: pin shows receiver status
// RULE_02 - Condition on: non-receiver source forces error high
// RULE_03 - Multichannel routing overrides group function selects
// RULE_04 - Error pin high impedance control
// RULE_05 - Error pin carries error or interrupt zero
// RULE_06 - Software keeps error source select zero
// RULE_07 - Non-PCM pin high impedance control
// RULE_08 - Non-PCM pin carries flag or interrupt one
// RULE_09 - Rate range bit selects wide/normal range
// RULE_10 - Condition off: clock status on lock change
// RULE_11 - Condition on: all main clock changes
// RULE_12 - Writing auto or receiver never pulses
// RULE_13 - Software keeps oscillator auto-stop zero
// RULE_14 - Software writes both source fields together
// RULE_15 - Clock status polarity selectable, low default
// RULE_16 - Validity immediate or aligned with data
// RULE_17 - Source register field layout
// RULE_18 - Auto selects receiver or converter output
// RULE_19 - Error is OR of enabled causes
// RULE_20 - Reserved bits store, no effect
module rxsp_ctrl
  import rxsp_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Receiver status
  input wire rxsp_err_s rx_err,
  input wire logic rx_pll_lock,
  input wire logic [7:0] rx_rate_khz,
  input wire logic rx_validity_flag,
  input wire logic dout_frame_strobe,
  input wire logic nonpcm_flag,
  input wire logic interrupt_line_zero,
  input wire logic interrupt_line_one,
  // Rate meter
  input wire logic [2:0] rate_meter_target,
  input wire logic main_rate_change,
  // Status pins
  output logic err_pin_o,
  output logic err_pin_oe,
  output logic nonpcm_pin_o,
  output logic nonpcm_pin_oe,
  output logic clock_status_pulse,
  output logic validity_out,
  // Configuration outputs
  output logic [2:0] main_src_active,
  output logic multichannel_routing_sel,
  output logic [1:0] pin_group_a_function,
  output logic [2:0] pin_group_b_function,
  output logic [2:0] pin_group_c_function,
  output logic receiver_rate_range,
  output logic rx_rate_in_range
);
  localparam logic [7:0] PULSE_CYC = 8'(CLOCK_STATUS_PULSE_PULSE_CYC);

  logic [7:0] errcfg_reg, rxset1_reg, rxset2_reg, rxset3_reg;
  logic [7:0] errcause_reg, autocause_reg, mainsrc_reg, mpfunc_reg;
  logic [7:0] rdata_next;
  logic [7:0] cs_cnt_reg;
  logic err_any, auto_adc, auto_adc_reg, lock_reg, err_shown;
  logic src_wr, src_wr_quiet, src_evt, auto_evt, rate_evt, lock_evt, cs_evt;
  logic cs_busy, vflag_reg, valign_reg;
  logic [2:0] pri_src, sec_src, src_next;
  logic [7:0] lo_khz, hi_khz;

  function automatic logic src_is_rx(input logic [2:0] s);
    src_is_rx = (s == SRC_AUTO) || (s == SRC_DIR);
  endfunction

  // Reserved bits are stored and read back but drive nothing [RULE_20]
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      errcfg_reg <= RST_ERRCFG;
      rxset1_reg <= RST_RXSET1;
      rxset2_reg <= RST_RXSET2;
      rxset3_reg <= RST_RXSET3;
      errcause_reg <= RST_ERRCAUSE;
      autocause_reg <= RST_AUTOCAUSE;
      mainsrc_reg <= RST_MAINSRC;
      mpfunc_reg <= RST_MPFUNC;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        ADDR_ERRCFG: errcfg_reg <= reg_wdata;
        ADDR_RXSET1: rxset1_reg <= reg_wdata;
        ADDR_RXSET2: rxset2_reg <= reg_wdata;
        ADDR_RXSET3: rxset3_reg <= reg_wdata;
        ADDR_ERRCAUSE: errcause_reg <= reg_wdata;
        ADDR_AUTOCAUSE: autocause_reg <= reg_wdata;
        ADDR_MAINSRC: mainsrc_reg <= reg_wdata;
        ADDR_MPFUNC: mpfunc_reg <= reg_wdata;
        default: ;
      endcase
    end
  end

  always_comb
  begin
    case (reg_addr)
      ADDR_ERRCFG: rdata_next = errcfg_reg;
      ADDR_RXSET1: rdata_next = rxset1_reg;
      ADDR_RXSET2: rdata_next = rxset2_reg;
      ADDR_RXSET3: rdata_next = rxset3_reg;
      ADDR_ERRCAUSE: rdata_next = errcause_reg;
      ADDR_AUTOCAUSE: rdata_next = autocause_reg;
      ADDR_MAINSRC: rdata_next = mainsrc_reg;
      ADDR_MPFUNC: rdata_next = mpfunc_reg;
      default: rdata_next = 8'h00;
    endcase
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      reg_rdata <= 8'h00;
    else
      reg_rdata <= reg_rd ? rdata_next : 8'h00;
  end

  assign sec_src = mainsrc_reg[SEC_LSB +: 3]; // [RULE_17]
  assign pri_src = mainsrc_reg[PRI_LSB +: 3]; // [RULE_17]

  assign err_any = |(rx_err & rxsp_err_s'(errcause_reg[5:0])); // [RULE_19]
  assign auto_adc = (rx_err.unlock & autocause_reg[0]) | (rx_err.validity & autocause_reg[2])
    | (nonpcm_flag & autocause_reg[3]) | (rx_err.rate_limit & autocause_reg[4])
    | (err_any & autocause_reg[AUTO_ERR_BIT]);
  // Auto resolves to converter on any cause enabled by bits 0, 2, 3, 4 or 6 [RULE_18]
  assign src_next = (pri_src == SRC_AUTO) ? (auto_adc ? SRC_ADC : SRC_DIR) : pri_src;

  // Forced high only for non-receiver sources under the condition bit [RULE_01] [RULE_02]
  assign err_shown = (errcfg_reg[ERROR_CONDITION_SEL_BIT] && !src_is_rx(pri_src)) ? 1'b1 : err_any;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      err_pin_o <= 1'b0;
      err_pin_oe <= 1'b0;
      nonpcm_pin_o <= 1'b0;
      nonpcm_pin_oe <= 1'b0;
      main_src_active <= SRC_DIR;
    end
    else
    begin
      err_pin_o <= errcfg_reg[ERR_PIN_SRC_SEL_BIT] ? interrupt_line_zero : err_shown; // [RULE_05]
      err_pin_oe <= !errcfg_reg[ERR_PIN_HIZ_BIT]; // [RULE_04]
      nonpcm_pin_o <= errcfg_reg[NONPCM_PIN_SRC_SEL_BIT] ? interrupt_line_one : nonpcm_flag; // [RULE_08]
      nonpcm_pin_oe <= !errcfg_reg[NONPCM_PIN_HIZ_BIT]; // [RULE_07]
      main_src_active <= src_next; // [RULE_18]
    end
  end

  // Multichannel routing masks the group selects [RULE_03]
  assign multichannel_routing_sel = errcfg_reg[MULTICHANNEL_ROUTING_SEL_BIT];
  assign pin_group_a_function = errcfg_reg[MULTICHANNEL_ROUTING_SEL_BIT] ? 2'h0 : mpfunc_reg[GRPA_LSB +: 2];
  assign pin_group_b_function = errcfg_reg[MULTICHANNEL_ROUTING_SEL_BIT] ? 3'h0 : mpfunc_reg[GRPB_LSB +: 3];
  assign pin_group_c_function = errcfg_reg[MULTICHANNEL_ROUTING_SEL_BIT] ? 3'h0 : mpfunc_reg[GRPC_LSB +: 3];

  // Rate range window [RULE_09]
  assign receiver_rate_range = rxset1_reg[RANGE_BIT];
  assign lo_khz = receiver_rate_range ? NORM_MIN_KHZ : WIDE_MIN_KHZ;
  assign hi_khz = receiver_rate_range ? NORM_MAX_KHZ : WIDE_MAX_KHZ;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      rx_rate_in_range <= 1'b0;
    else
      rx_rate_in_range <= (rx_rate_khz >= lo_khz) && (rx_rate_khz <= hi_khz); // [RULE_09]
  end

  // Clock status events
  assign src_wr = reg_wr && (reg_addr == ADDR_MAINSRC);
  // Both fields to auto or receiver: no pulse [RULE_12]
  assign src_wr_quiet = src_is_rx(reg_wdata[SEC_LSB +: 3]) && src_is_rx(reg_wdata[PRI_LSB +: 3]);
  // One write carries both fields, so one event per update [RULE_14]
  assign src_evt = src_wr && !src_wr_quiet; // [RULE_11] [RULE_12]
  assign auto_evt = (sec_src == SRC_AUTO) && (pri_src == SRC_AUTO)
    && (auto_adc != auto_adc_reg); // [RULE_11]
  assign rate_evt = main_rate_change && (rate_meter_target == TGT_MAIN); // [RULE_11]
  assign lock_evt = rx_pll_lock != lock_reg; // [RULE_10]
  assign cs_evt = lock_evt || (rxset2_reg[CSCON_BIT] && (src_evt || auto_evt || rate_evt));
  assign cs_busy = cs_cnt_reg != 8'h00;

  // Retriggers on a new event so back-to-back changes merge into one pulse
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      lock_reg <= 1'b0;
      auto_adc_reg <= 1'b0;
      cs_cnt_reg <= 8'h00;
    end
    else
    begin
      lock_reg <= rx_pll_lock;
      auto_adc_reg <= auto_adc;
      if (cs_evt)
        cs_cnt_reg <= PULSE_CYC; // [RULE_10] [RULE_11]
      else if (cs_busy)
        cs_cnt_reg <= cs_cnt_reg - 8'h01;
    end
  end

  // Oscillator auto-stop must stay clear for this pulse to be trusted [RULE_13]
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      clock_status_pulse <= 1'b1;
    else
      clock_status_pulse <= ~(cs_busy ^ rxset2_reg[CSPOL_BIT]); // [RULE_15]
  end

  // Validity: immediate or latched on the data frame strobe
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      vflag_reg <= 1'b0;
      valign_reg <= 1'b0;
    end
    else
    begin
      vflag_reg <= rx_validity_flag;
      if (dout_frame_strobe)
        valign_reg <= rx_validity_flag;
    end
  end

  assign validity_out = rxset2_reg[VDLY_BIT] ? valign_reg : vflag_reg; // [RULE_16]

  // Interrupt zero on the error pin is legal only with no conflicting use [RULE_06]

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  property p_err_rx;
    !errcfg_reg[ERROR_CONDITION_SEL_BIT] && !errcfg_reg[ERR_PIN_SRC_SEL_BIT] |=> err_pin_o == $past(err_any);
  endproperty
  a_err_rx: assert property (p_err_rx) else $error("error pin not receiver status"); // [RULE_01]

  property p_err_forced;
    errcfg_reg[ERROR_CONDITION_SEL_BIT] && !errcfg_reg[ERR_PIN_SRC_SEL_BIT] && !src_is_rx(pri_src) |=> err_pin_o;
  endproperty
  a_err_forced: assert property (p_err_forced) else $error("error pin not forced high"); // [RULE_02]

  property p_multichannel_routing_sel;
    multichannel_routing_sel |-> (pin_group_a_function == 2'h0) && (pin_group_c_function == 3'h0)
      && (pin_group_b_function == 3'h0);
  endproperty
  a_multichannel_routing_sel: assert property (p_multichannel_routing_sel) else $error("group select active in routing mode"); // [RULE_03]

  property p_err_hiz;
    errcfg_reg[ERR_PIN_HIZ_BIT] |=> !err_pin_oe;
  endproperty
  a_err_hiz: assert property (p_err_hiz) else $error("error pin driven while released"); // [RULE_04]

  property p_err_interrupt_line_zero;
    errcfg_reg[ERR_PIN_SRC_SEL_BIT] |=> err_pin_o == $past(interrupt_line_zero);
  endproperty
  a_err_interrupt_line_zero: assert property (p_err_interrupt_line_zero) else $error("error pin not interrupt zero"); // [RULE_05]

  property p_np_hiz;
    // Pins still hold reset values one edge after release
    rstn && !errcfg_reg[NONPCM_PIN_HIZ_BIT] |=> nonpcm_pin_oe;
  endproperty
  a_np_hiz: assert property (p_np_hiz) else $error("non-PCM pin not driven"); // [RULE_07]

  property p_np_src;
    !errcfg_reg[NONPCM_PIN_SRC_SEL_BIT] |=> nonpcm_pin_o == $past(nonpcm_flag);
  endproperty
  a_np_src: assert property (p_np_src) else $error("non-PCM pin not flag"); // [RULE_08]

  property p_range;
    receiver_rate_range && (rx_rate_khz == 8'h1B) |=> !rx_rate_in_range;
  endproperty
  a_range: assert property (p_range) else $error("normal range accepts 27 kHz"); // [RULE_09]

  property p_cs_lock;
    $changed(rx_pll_lock) |=> cs_busy [*8];
  endproperty
  a_cs_lock: assert property (p_cs_lock) else $error("no clock status on lock change"); // [RULE_10]

  property p_cs_rate;
    rxset2_reg[CSCON_BIT] && rate_evt |=> cs_cnt_reg == PULSE_CYC;
  endproperty
  a_cs_rate: assert property (p_cs_rate) else $error("no clock status on rate change"); // [RULE_11]

  property p_cs_quiet;
    src_wr && src_wr_quiet && !lock_evt && !auto_evt && !rate_evt |=> cs_cnt_reg != PULSE_CYC;
  endproperty
  a_cs_quiet: assert property (p_cs_quiet) else $error("pulse on auto/receiver write"); // [RULE_12]

  property p_cs_pol;
    ##1 clock_status_pulse == ($past(cs_busy) ~^ $past(rxset2_reg[CSPOL_BIT]));
  endproperty
  a_cs_pol: assert property (p_cs_pol) else $error("clock status polarity wrong"); // [RULE_15]

  property p_validity_out;
    // Output mux follows the delay bit at once, so skip a write to it
    !rxset2_reg[VDLY_BIT] && !(reg_wr && (reg_addr == ADDR_RXSET2))
      |=> validity_out == $past(rx_validity_flag);
  endproperty
  a_validity_out: assert property (p_validity_out) else $error("validity not immediate"); // [RULE_16]

  property p_auto;
    pri_src == SRC_AUTO |=> main_src_active == ($past(auto_adc) ? SRC_ADC : SRC_DIR);
  endproperty
  a_auto: assert property (p_auto) else $error("auto source resolved wrongly"); // [RULE_18]
endmodule
`default_nettype wire

// *** rtl/rxsp_pkg.sv ***
// Constants and types of the receiver status and pin control block
package rxsp_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_ERRCFG = 8'h20;
  localparam logic [7:0] ADDR_RXSET1 = 8'h21;
  localparam logic [7:0] ADDR_RXSET2 = 8'h22;
  localparam logic [7:0] ADDR_RXSET3 = 8'h23;
  localparam logic [7:0] ADDR_ERRCAUSE = 8'h25;
  localparam logic [7:0] ADDR_AUTOCAUSE = 8'h26;
  localparam logic [7:0] ADDR_MAINSRC = 8'h6B;
  localparam logic [7:0] ADDR_MPFUNC = 8'h6F;
  // Reset values
  localparam logic [7:0] RST_ERRCFG = 8'h00;
  localparam logic [7:0] RST_RXSET1 = 8'h00;
  localparam logic [7:0] RST_RXSET2 = 8'h01;
  localparam logic [7:0] RST_RXSET3 = 8'h04;
  localparam logic [7:0] RST_ERRCAUSE = 8'h01;
  localparam logic [7:0] RST_AUTOCAUSE = 8'h01;
  localparam logic [7:0] RST_MAINSRC = 8'h00;
  localparam logic [7:0] RST_MPFUNC = 8'h00;
  // Field positions
  localparam int ERROR_CONDITION_SEL_BIT = 6;
  localparam int MULTICHANNEL_ROUTING_SEL_BIT = 5;
  localparam int ERR_PIN_HIZ_BIT = 3;
  localparam int ERR_PIN_SRC_SEL_BIT = 2;
  localparam int NONPCM_PIN_HIZ_BIT = 1;
  localparam int NONPCM_PIN_SRC_SEL_BIT = 0;
  localparam int RANGE_BIT = 4;
  localparam int CSCON_BIT = 6;
  localparam int CSPOL_BIT = 4;
  localparam int VDLY_BIT = 0;
  localparam int AUTO_ERR_BIT = 6;
  localparam int SEC_LSB = 4;
  localparam int PRI_LSB = 0;
  localparam int GRPA_LSB = 6;
  localparam int GRPB_LSB = 3;
  localparam int GRPC_LSB = 0;
  // Source selector codes and the rate meter main target code
  localparam logic [2:0] SRC_AUTO = 3'h0;
  localparam logic [2:0] SRC_DIR = 3'h1;
  localparam logic [2:0] SRC_ADC = 3'h2;
  localparam logic [2:0] SRC_AUX0 = 3'h3;
  localparam logic [2:0] SRC_AUX1 = 3'h4;
  localparam logic [2:0] SRC_AUX2 = 3'h5;
  localparam logic [2:0] TGT_MAIN = 3'h5;
  // Acceptable rate bounds in kHz: 7..216 wide, 28..108 normal
  localparam logic [7:0] WIDE_MIN_KHZ = 8'h07;
  localparam logic [7:0] WIDE_MAX_KHZ = 8'hD8;
  localparam logic [7:0] NORM_MIN_KHZ = 8'h1C;
  localparam logic [7:0] NORM_MAX_KHZ = 8'h6C;
  // Clock status pulse timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int CLOCK_STATUS_PULSE_PULSE_NS = 1000;
  localparam int CLOCK_STATUS_PULSE_PULSE_CYC = (CLOCK_STATUS_PULSE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Receiver error causes, laid out as the cause enable bits
  typedef struct packed {
    logic rate_change;
    logic rate_limit;
    logic nonpcm;
    logic validity;
    logic parity;
    logic unlock;
  } rxsp_err_s;
endpackage

// *** verification/rxsp_host_mon.sv ***
// Host side model resolving the two shared status lines
`timescale 1ns/1ps
`default_nettype none
module rxsp_host_mon (
  // Clock
  input wire logic clk,
  // Device pins
  input wire logic err_o,
  input wire logic err_oe,
  input wire logic np_o,
  input wire logic np_oe,
  // Resolved lines
  output logic err_line,
  output logic np_line
);
  // No pull on these lines, so a released line wanders
  logic wander = 1'b0;
  always @(posedge clk) wander <= ~wander;
  assign err_line = err_oe ? err_o : wander;
  assign np_line = np_oe ? np_o : wander;
endmodule
`default_nettype wire

// *** verification/tb_top.sv ***
// Self-checking bench for the receiver status and pin control block
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import rxsp_pkg::*;
;
  typedef struct {int k; logic [9:0] v; int c;} rxsp_note_s;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  rxsp_err_s rx_err = '0;
  logic rx_pll_lock = 1'b0;
  logic [7:0] rx_rate_khz = 8'h00;
  logic rx_validity_flag = 1'b0;
  logic dout_frame_strobe = 1'b0;
  logic nonpcm_flag = 1'b0;
  logic interrupt_line_zero = 1'b0;
  logic interrupt_line_one = 1'b0;
  logic [2:0] rate_meter_target = 3'h0;
  logic main_rate_change = 1'b0;
  logic [7:0] reg_rdata;
  logic err_pin_o, err_pin_oe, nonpcm_pin_o, nonpcm_pin_oe, clock_status_pulse, validity_out;
  logic [2:0] main_src_active, pin_group_b_function, pin_group_c_function;
  logic [1:0] pin_group_a_function;
  logic multichannel_routing_sel, receiver_rate_range, rx_rate_in_range, err_line, np_line;
  int error_cnt = 0;
  int checked = 0;
  int cyc = 0;
  int i;
  logic [31:0] r;
  logic [7:0] rt;
  rxsp_note_s q[$];
  rxsp_note_s nt;
  string nm[10] = '{"rdata", "err_line", "err_oe", "np_line", "np_oe", "clock_status_pulse", "validity_out",
    "src", "in_range", "cfg"};
  logic [7:0] ad[6] = '{ADDR_ERRCFG, ADDR_RXSET1, ADDR_RXSET2, ADDR_RXSET3, ADDR_MAINSRC, 8'h30};
  logic [7:0] rv[6] = '{8'h00, 8'h00, 8'h01, 8'h04, RST_MAINSRC, 8'h00};
  logic [7:0] rates[8] = '{8'h06, 8'h07, 8'hD8, 8'hD9, 8'h1B, 8'h1C, 8'h6C, 8'h6D};
  logic [7:0] srcs[7] = '{8'h33, 8'h44, 8'h55, 8'h22, 8'h11, 8'h00, 8'h10};

  rxsp_ctrl dut (.clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .rx_err,
    .rx_pll_lock, .rx_rate_khz, .rx_validity_flag, .dout_frame_strobe, .nonpcm_flag,
    .interrupt_line_zero, .interrupt_line_one, .rate_meter_target, .main_rate_change,
    .err_pin_o, .err_pin_oe, .nonpcm_pin_o, .nonpcm_pin_oe, .clock_status_pulse, .validity_out,
    .main_src_active, .multichannel_routing_sel, .pin_group_a_function, .pin_group_b_function,
    .pin_group_c_function, .receiver_rate_range, .rx_rate_in_range);
  rxsp_host_mon host (.clk, .err_o(err_pin_o), .err_oe(err_pin_oe), .np_o(nonpcm_pin_o),
    .np_oe(nonpcm_pin_oe), .err_line, .np_line);

  always #5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  function automatic logic [9:0] seen(int k);
    case (k)
      0: seen = {2'h0, reg_rdata};
      1: seen = {9'h0, err_line};
      2: seen = {9'h0, err_pin_oe};
      3: seen = {9'h0, np_line};
      4: seen = {9'h0, nonpcm_pin_oe};
      5: seen = {9'h0, clock_status_pulse};
      6: seen = {9'h0, validity_out};
      7: seen = {7'h0, main_src_active};
      8: seen = {9'h0, rx_rate_in_range};
      default: seen = {multichannel_routing_sel, pin_group_a_function, pin_group_b_function,
        pin_group_c_function, receiver_rate_range};
    endcase
  endfunction

  task automatic check(string n, logic [9:0] s, logic [9:0] e);
    checked++;
    if (s !== e)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask

  // Results are compared in the cycle noted beside them
  always @(negedge clk)
  begin
    while (q.size() > 0 && q[0].c <= cyc)
    begin
      nt = q.pop_front();
      check(nm[nt.k], seen(nt.k), nt.v);
    end
  end

  task automatic ex(int k, logic [9:0] v, int d);
    q.push_back('{k, v, cyc + 1 + d});
  endtask

  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(logic [7:0] a, logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    ex(0, {2'h0, e}, 1);
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask

  task automatic idle(int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic summarize();
    if (error_cnt == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    r = $urandom(87);
    idle(4);
    rstn <= 1'b1;
    foreach (ad[j]) rd(ad[j], rv[j]);
    for (i = 0; i < 6; i++)
    begin
      r = $urandom;
      wr(ad[i], r[7:0]);
      rd(ad[i], i == 5 ? 8'h00 : r[7:0]);
    end
    wr(ADDR_ERRCFG, 8'h00);
    wr(ADDR_RXSET2, 8'h01);
    for (i = 0; i < 16; i++)
    begin
      r = $urandom;
      wr(ADDR_ERRCFG, {4'h0, i[3:0]});
      rx_err <= {5'h0, r[0]};
      interrupt_line_zero <= r[1];
      interrupt_line_one <= r[2];
      nonpcm_flag <= r[3];
      ex(2, {9'h0, !i[3]}, 1);
      if (!i[3]) ex(1, {9'h0, i[2] ? r[1] : r[0]}, 1);
      ex(4, {9'h0, !i[1]}, 1);
      if (!i[1]) ex(3, {9'h0, i[0] ? r[2] : r[3]}, 1);
      idle(2);
    end
    wr(ADDR_ERRCFG, 8'h00);
    wr(ADDR_ERRCAUSE, 8'h06);
    rx_err <= 6'h39;
    ex(1, 10'h000, 1);
    idle(2);
    rx_err <= 6'h04;
    ex(1, 10'h001, 1);
    wr(ADDR_ERRCAUSE, 8'h01);
    rx_err <= 6'h00;
    wr(ADDR_ERRCFG, 8'h40);
    for (i = 0; i < 6; i++)
    begin
      wr(ADDR_MAINSRC, {1'b0, i[2:0], 1'b0, i[2:0]});
      ex(1, {9'h0, i > 1}, 1);
      ex(7, {7'h0, i == 0 ? SRC_DIR : i[2:0]}, 1);
      idle(2);
    end
    r = $urandom;
    wr(ADDR_MPFUNC, r[7:0]);
    wr(ADDR_ERRCFG, 8'h20);
    wr(ADDR_RXSET1, 8'h10);
    ex(9, 10'h201, 1);
    wr(ADDR_ERRCFG, 8'h00);
    ex(9, {1'b0, r[7:0], 1'b1}, 1);
    for (i = 0; i < 16; i++)
    begin
      rt = rates[i[2:0]];
      wr(ADDR_RXSET1, {3'h0, i[3], 4'h0});
      rx_rate_khz <= rt;
      ex(8, {9'h0, i[3] ? rt >= 8'h1C && rt <= 8'h6C : rt >= 8'h07 && rt <= 8'hD8}, 1);
      idle(2);
    end
    wr(ADDR_RXSET2, 8'h00);
    rx_validity_flag <= 1'b1;
    ex(6, 10'h001, 1);
    wr(ADDR_RXSET2, 8'h01);
    dout_frame_strobe <= 1'b1;
    @(posedge clk);
    dout_frame_strobe <= 1'b0;
    rx_validity_flag <= 1'b0;
    ex(6, 10'h001, 3);
    idle(4);
    dout_frame_strobe <= 1'b1;
    ex(6, 10'h000, 1);
    @(posedge clk);
    dout_frame_strobe <= 1'b0;
    // Error select kept 0 and oscillator never auto-stopped while pulses matter
    idle(4);
    rx_pll_lock <= 1'b1;
    ex(5, 10'h001, 1);
    ex(5, 10'h000, 2);
    ex(5, 10'h000, 101);
    ex(5, 10'h001, 102);
    idle(104);
    wr(ADDR_MAINSRC, 8'h22);
    ex(5, 10'h001, 2);
    wr(ADDR_RXSET2, 8'h51);
    for (i = 0; i < 7; i++)
    begin
      wr(ADDR_MAINSRC, srcs[i]);
      ex(5, {9'h0, i < 4}, 1);
      ex(5, {9'h0, i < 4}, 100);
      ex(5, 10'h000, 101);
      idle(103);
    end
    for (i = 0; i < 2; i++)
    begin
      rate_meter_target <= i ? 3'h4 : 3'h5;
      main_rate_change <= 1'b1;
      ex(5, {9'h0, i == 0}, 2);
      @(posedge clk);
      main_rate_change <= 1'b0;
      idle(104);
    end
    // Auto switching only pulses with both source fields on auto
    wr(ADDR_MAINSRC, 8'h00);
    ex(5, 10'h000, 1);
    rx_err <= 6'h01;
    ex(7, {7'h0, SRC_ADC}, 1);
    ex(5, 10'h001, 3);
    for (i = 0; i < 50 && q.size() > 0; i++) @(posedge clk);
    if (q.size() > 0) error_cnt++;
    summarize();
  end
endmodule
`default_nettype wire
